/* File: core/rfu_pkg.sv */
// constants shared by the result and image-update register bank
// assumes word-indexed registers on a 32-bit lite bus, byte address = 4*index
package rfu_pkg;
  // bus geometry and answers
  localparam int ADDR_W = 9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // register indices, byte address is four times the index
  localparam logic [6:0] IDX_OFFSET = 7'h38;
  localparam logic [6:0] IDX_LUX_HI = 7'h3C;
  localparam logic [6:0] IDX_LUX_LO = 7'h3D;
  localparam logic [6:0] IDX_CCT_HI = 7'h3E;
  localparam logic [6:0] IDX_CCT_LO = 7'h3F;
  localparam logic [6:0] IDX_CTRL = 7'h48;
  localparam logic [6:0] IDX_CNT_HI = 7'h49;
  localparam logic [6:0] IDX_CNT_LO = 7'h4A;
  localparam logic [6:0] IDX_PAYLOAD = 7'h4B;

  // control byte bit positions
  localparam int CTRL_START = 7;
  localparam int CTRL_STOP = 6;
  localparam int CTRL_DONE = 5;
  localparam int CTRL_LOCK = 4;
  localparam int CTRL_SWITCH = 3;
  localparam int CTRL_FIRST = 2;
  localparam int CTRL_ERR = 1;
  localparam int CTRL_CHK = 0;

  // image geometry in external flash
  localparam logic [23:0] IMG1_BASE = 24'h012000;
  localparam logic [23:0] IMG2_BASE = 24'h022000;
  localparam logic [15:0] IMAGE_BYTES = 16'hE000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [7:0] PAYLOAD_RST = 8'h00;

  // update sequencer states
  typedef enum logic [2:0] {
    RFU_IDLE = 3'b001,
    RFU_RECV = 3'b010,
    RFU_DONE = 3'b100
  } rfu_fw_e;
endpackage

/* File: core/rfu_snapshot.sv */
// result snapshot register with a hold for split high/low reads
// assumes update, sample and hold strobes come from the aclk domain
`timescale 1ns/1ps
`default_nettype none
module rfu_snapshot #(
  parameter int W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic update,
  input wire logic [W-1:0] sample,
  input wire logic hold_set,
  input wire logic hold_clr,
  output logic [W-1:0] value,
  output logic held
);
  typedef struct packed {
    logic [W-1:0] value;
    logic held;
  } rfu_snap_s;
  rfu_snap_s q;
  rfu_snap_s n;

  // a fresh result is dropped while held; the next one refills it
  always_comb begin
    n = q;
    if (update && !q.held && !hold_set) begin
      n.value = sample;
    end
    if (hold_set) begin
      n.held = 1'b1;
    end else if (hold_clr) begin
      n.held = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign value = q.value;
  assign held = q.held;
endmodule // rfu_snapshot
`default_nettype wire

/* File: core/rfu_flash_port.sv */
// one-byte holding stage toward the flash programming engine
// assumes the engine runs on aclk and answers with a ready level
`timescale 1ns/1ps
`default_nettype none
module rfu_flash_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic push,
  input wire logic [23:0] push_addr,
  input wire logic [7:0] push_data,
  input wire logic flash_ready,
  output logic flash_valid,
  output logic [23:0] flash_addr,
  output logic [7:0] flash_data
);
  typedef struct packed {
    logic valid;
    logic [23:0] addr;
    logic [7:0] data;
  } rfu_port_s;
  rfu_port_s q;
  rfu_port_s n;

  // a push may replace a byte only in the cycle it is taken
  always_comb begin
    n = q;
    if (push) begin
      n.valid = 1'b1;
      n.addr = push_addr;
      n.data = push_data;
    end else if (flash_ready) begin
      n.valid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign flash_valid = q.valid;
  assign flash_addr = q.addr;
  assign flash_data = q.data;
endmodule // rfu_flash_port
`default_nettype wire

/* File: core/rfu_regs.sv */
// result and image-update register bank behind an AXI4-Lite slave
// assumes results and flash engine share aclk; flash ready is a level
//
// Notes on behaviour
// - chromaticity offset float readable at index 0x38
// - illuminance 16 bit, high 0x3C, low 0x3D
// - colour temperature 16 bit, high 0x3E, low 0x3F
// - images stored at 0x12000 and 0x22000
// - image complete only after all 56k bytes
// - start bit 7 enters update configuration once
// - stop bit 6 returns sequencer to idle
// - bit 5 shows every image byte received
// - bit 4 locks current image for next start
// - switch bit 3 exchanges the selected image
// - bit 2 high while first image active
// - bit 1 flags an update error
// - bit 0 reports inactive image checksum valid
// - byte counter readable at 0x49/0x4A, resets zero
// - payload port 0x4B takes one byte per write
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rfu_regs #(
  parameter logic [15:0] IMAGE_SIZE = rfu_pkg::IMAGE_BYTES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [rfu_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rfu_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic result_update,
  input wire logic [31:0] offset_value,
  input wire logic [15:0] lux_value,
  input wire logic [15:0] cct_value,
  input wire logic flash_ready,
  output logic flash_valid,
  output logic [23:0] flash_addr,
  output logic [7:0] flash_data,
  output logic boot_lock,
  output logic first_image_active
);
  import rfu_pkg::*;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic w_got;
    logic [6:0] widx;
    logic [7:0] wbyte;
    logic wlane;
    rfu_fw_e state;
    logic [15:0] count;
    logic complete;
    logic err;
    logic lock;
    logic first_act;
    logic [1:0] chk_ok;
    logic [7:0] sum;
    logic [7:0] payload;
  } rfu_top_s;

  localparam rfu_top_s RST = '{
    awready: 1'b1, wready: 1'b1, arready: 1'b1, state: RFU_IDLE,
    first_act: 1'b1, count: COUNT_RST, payload: PAYLOAD_RST, default: '0};

  rfu_top_s q;
  rfu_top_s n;
  logic [6:0] ridx;
  logic rd_fire;
  logic wr_fire;
  logic push;
  logic [23:0] push_addr;
  logic lux_hi_rd;
  logic lux_lo_rd;
  logic cct_hi_rd;
  logic cct_lo_rd;
  logic [31:0] offset_snap;
  logic [15:0] lux_snap;
  logic [15:0] cct_snap;
  logic lux_held;
  logic cct_held;

  // read decode strobes, combinational so the hold lands with the read
  assign ridx = s_axi_araddr[ADDR_W-1:2];
  assign rd_fire = s_axi_arvalid && q.arready;
  assign wr_fire = q.aw_got && q.w_got && !q.bvalid;
  assign lux_hi_rd = rd_fire && (ridx == IDX_LUX_HI);
  assign lux_lo_rd = rd_fire && (ridx == IDX_LUX_LO);
  assign cct_hi_rd = rd_fire && (ridx == IDX_CCT_HI);
  assign cct_lo_rd = rd_fire && (ridx == IDX_CCT_LO);
  assign push_addr = (q.first_act ? IMG2_BASE : IMG1_BASE) + {8'h00, q.count};

  // word result is read in one beat, so it never needs a hold
  rfu_snapshot #(.W(32)) u_offset (
    .aclk(aclk),
    .aresetn(aresetn),
    .update(result_update),
    .sample(offset_value),
    .hold_set(1'b0),
    .hold_clr(1'b0),
    .value(offset_snap),
    .held()
  );

  rfu_snapshot #(.W(16)) u_lux (
    .aclk(aclk),
    .aresetn(aresetn),
    .update(result_update),
    .sample(lux_value),
    .hold_set(lux_hi_rd),
    .hold_clr(lux_lo_rd),
    .value(lux_snap),
    .held(lux_held)
  );

  rfu_snapshot #(.W(16)) u_cct (
    .aclk(aclk),
    .aresetn(aresetn),
    .update(result_update),
    .sample(cct_value),
    .hold_set(cct_hi_rd),
    .hold_clr(cct_lo_rd),
    .value(cct_snap),
    .held(cct_held)
  );

  rfu_flash_port u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .push(push),
    .push_addr(push_addr),
    .push_data(q.wbyte),
    .flash_ready(flash_ready),
    .flash_valid(flash_valid),
    .flash_addr(flash_addr),
    .flash_data(flash_data)
  );

  // bus channels, control writes, payload intake and read mux
  always_comb begin
    n = q;
    push = 1'b0;
    if (s_axi_awvalid && q.awready) begin
      n.aw_got = 1'b1;
      n.widx = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_got = 1'b1;
      n.wbyte = s_axi_wdata[7:0];
      n.wlane = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (wr_fire) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (q.widx)
        IDX_CTRL: begin
          if (q.wlane) begin
            if (q.wbyte[CTRL_STOP]) begin
              n.state = RFU_IDLE;
              n.count = COUNT_RST;
              n.complete = 1'b0;
              n.err = 1'b0;
              n.sum = 8'h00;
            end else if (q.wbyte[CTRL_START] && q.state == RFU_IDLE) begin
              n.state = RFU_RECV;
              n.count = COUNT_RST;
              n.complete = 1'b0;
              n.err = 1'b0;
              n.sum = 8'h00;
              n.chk_ok[q.first_act] = 1'b0;
            end
            n.lock = q.wbyte[CTRL_LOCK];
            if (q.wbyte[CTRL_SWITCH] && q.state != RFU_RECV &&
                !q.wbyte[CTRL_STOP] && !q.wbyte[CTRL_START]) begin
              n.first_act = !q.first_act;
            end
          end
        end
        IDX_PAYLOAD: begin
          if (q.wlane) begin
            n.payload = q.wbyte;
            if (q.state == RFU_RECV) begin
              if (flash_valid && !flash_ready) begin
                n.err = 1'b1;
              end else begin
                push = 1'b1;
                n.count = q.count + 16'h0001;
                n.sum = q.sum + q.wbyte;
                if (q.count == IMAGE_SIZE - 16'h0001) begin
                  n.complete = 1'b1;
                  n.state = RFU_DONE;
                  n.chk_ok[q.first_act] = (q.sum + q.wbyte) == 8'h00;
                end
              end
            end else if (q.state == RFU_IDLE) begin
              n.err = 1'b1;
            end
          end
        end
        IDX_OFFSET, IDX_LUX_HI, IDX_LUX_LO, IDX_CCT_HI, IDX_CCT_LO,
        IDX_CNT_HI, IDX_CNT_LO: begin
          n.bresp = RESP_OKAY;
        end
        default: begin
          n.bresp = RESP_DECERR;
        end
      endcase
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (rd_fire) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = 32'h00000000;
      case (ridx)
        IDX_OFFSET: n.rdata = offset_snap;
        IDX_LUX_HI: n.rdata[7:0] = lux_snap[15:8];
        IDX_LUX_LO: n.rdata[7:0] = lux_snap[7:0];
        IDX_CCT_HI: n.rdata[7:0] = cct_snap[15:8];
        IDX_CCT_LO: n.rdata[7:0] = cct_snap[7:0];
        IDX_CTRL: begin
          n.rdata[CTRL_START] = q.state != RFU_IDLE;
          n.rdata[CTRL_DONE] = q.complete;
          n.rdata[CTRL_LOCK] = q.lock;
          n.rdata[CTRL_FIRST] = q.first_act;
          n.rdata[CTRL_ERR] = q.err;
          n.rdata[CTRL_CHK] = q.chk_ok[q.first_act];
        end
        IDX_CNT_HI: n.rdata[7:0] = q.count[15:8];
        IDX_CNT_LO: n.rdata[7:0] = q.count[7:0];
        IDX_PAYLOAD: n.rdata[7:0] = q.payload;
        default: n.rresp = RESP_DECERR;
      endcase
    end
    n.arready = !n.rvalid;
  end

  // single register stage for all bank state outside the snapshots and the flash port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= RST;
    end else begin
      q <= n;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign boot_lock = q.lock;
  assign first_image_active = q.first_act;

  // checks on the documented behaviour
  sequence s_ctrl_wr;
    wr_fire && q.widx == IDX_CTRL && q.wlane;
  endsequence
  sequence s_pay_wr;
    wr_fire && q.widx == IDX_PAYLOAD && q.wlane;
  endsequence

  property p_offset_read;
    @(posedge aclk) disable iff (!aresetn)
    rd_fire && ridx == IDX_OFFSET |=>
      q.rvalid && q.rdata == $past(offset_snap);
  endproperty
  a_offset_read: assert property (p_offset_read)
    else $error("offset word read mismatch");

  property p_lux_low;
    @(posedge aclk) disable iff (!aresetn)
    lux_lo_rd |=> q.rdata == {24'h000000, $past(lux_snap[7:0])};
  endproperty
  a_lux_low: assert property (p_lux_low)
    else $error("illuminance low byte mismatch");

  property p_cct_high;
    @(posedge aclk) disable iff (!aresetn)
    cct_hi_rd |=> q.rdata == {24'h000000, $past(cct_snap[15:8])};
  endproperty
  a_cct_high: assert property (p_cct_high)
    else $error("temperature high byte mismatch");

  property p_lux_hold;
    @(posedge aclk) disable iff (!aresetn)
    lux_hi_rd ##1 (lux_held && !lux_lo_rd) |=> $stable(lux_snap);
  endproperty
  a_lux_hold: assert property (p_lux_hold)
    else $error("illuminance changed between byte reads");

  property p_first_addr;
    @(posedge aclk) disable iff (!aresetn)
    push && q.count == COUNT_RST && q.first_act |=>
      flash_valid && flash_addr == IMG2_BASE;
  endproperty
  a_first_addr: assert property (p_first_addr)
    else $error("first image byte at wrong flash address");

  property p_complete;
    @(posedge aclk) disable iff (!aresetn)
    push && q.count == IMAGE_SIZE - 16'h0001 |=>
      q.complete && q.state == RFU_DONE ##1 q.count == IMAGE_SIZE;
  endproperty
  a_complete: assert property (p_complete)
    else $error("image not complete at full size");

  property p_count;
    @(posedge aclk) disable iff (!aresetn)
    s_pay_wr and (q.state == RFU_RECV && !(flash_valid && !flash_ready))
      |=> q.count == $past(q.count) + 16'h0001;
  endproperty
  a_count: assert property (p_count)
    else $error("byte counter did not advance");

  property p_stop;
    @(posedge aclk) disable iff (!aresetn)
    s_ctrl_wr and q.wbyte[CTRL_STOP] |=>
      q.state == RFU_IDLE && q.count == COUNT_RST && !q.complete;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not reset sequencer");

  property p_switch;
    @(posedge aclk) disable iff (!aresetn)
    s_ctrl_wr and (q.wbyte[CTRL_SWITCH] && q.state != RFU_RECV &&
      !q.wbyte[CTRL_STOP] && !q.wbyte[CTRL_START])
      |=> q.first_act != $past(q.first_act);
  endproperty
  a_switch: assert property (p_switch)
    else $error("switch did not exchange images");

  property p_idle_err;
    @(posedge aclk) disable iff (!aresetn)
    s_pay_wr and q.state == RFU_IDLE |=> q.err [*2];
  endproperty
  a_idle_err: assert property (p_idle_err)
    else $error("payload outside update not flagged");
endmodule // rfu_regs
`default_nettype wire

/* File: testbench/rfu_flash_model.sv */
// stand-in for the flash programming engine behind the payload port
// assumes one aclk domain; stall holds ready low for refusal scenarios
`timescale 1ns/1ps
`default_nettype none
module rfu_flash_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic flash_valid,
  input wire logic stall,
  input wire logic [1:0] lat,
  output logic flash_ready
);
  logic [1:0] wait_cnt;

  // cycles a byte has waited; a late answer exercises the hold
  always_ff @(posedge aclk) begin
    if (!aresetn || !flash_valid || flash_ready) begin
      wait_cnt <= 2'h0;
    end else if (wait_cnt != 2'h3) begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end

  // level answer; stall keeps it low however long the byte waits
  assign flash_ready = flash_valid && !stall && (wait_cnt >= lat);
endmodule // rfu_flash_model
`default_nettype wire

/* File: testbench/rfu_regs_tb.sv */
// self-checking bench for the result and image-update register bank
// assumes a lite-bus host driven here and the flash engine stand-in
`timescale 1ns/1ps
`default_nettype none
module rfu_regs_tb;
  import rfu_pkg::*;
  typedef struct packed {
    logic [31:0] e;
    logic [31:0] m;
    logic [1:0] r;
  } rfu_exp_s;
  // short image keeps the run brief; all counts derive from it
  localparam logic [15:0] SIZE = 16'h0010;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, upd, stall, fready, fvalid;
  logic lock, first, lane0;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, offs, rnd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, lat;
  logic [15:0] lux, cct, old;
  logic [23:0] faddr;
  logic [7:0] fdata, b, sum;
  int failures, n_tests, seed, n;
  rfu_exp_s x;
  rfu_exp_s rq[$];
  logic [1:0] bq[$];
  logic [31:0] fq[$];

  rfu_regs #(.IMAGE_SIZE(SIZE)) u_rfu_regs (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .result_update(upd),
    .offset_value(offs), .lux_value(lux), .cct_value(cct),
    .flash_ready(fready), .flash_valid(fvalid), .flash_addr(faddr),
    .flash_data(fdata), .boot_lock(lock), .first_image_active(first));
  rfu_flash_model u_rfu_flash_model (.aclk(aclk), .aresetn(aresetn),
    .flash_valid(fvalid), .stall(stall), .lat(lat), .flash_ready(fready));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_data(input string nm, input logic [31:0] e, got);
    n_tests++;
    if (got !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, got);
    end
  endtask

  task automatic cmp_resp(input string nm, input logic [1:0] e, got);
    n_tests++;
    if (got !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, got);
    end
  endtask

  // every wait is bounded; a hang ends the run as a mismatch
  task automatic guard(inout int k);
    k++;
    if (k > 200) begin
      failures++;
      summarize();
    end
  endtask

  task automatic wr(input logic [6:0] idx, input logic [7:0] d,
                    input logic [1:0] r);
    bit aw, w;
    int k;
    @(posedge aclk);
    bq.push_back(r);
    rnd = $random(seed);
    awaddr <= {idx, 2'b00};
    wdata <= {rnd[31:8], d};
    // upper lanes random; lane zero alone qualifies the byte
    wstrb <= {rnd[2:0], lane0};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 0;
    w = 0;
    k = 0;
    while (!(aw && w)) begin
      @(negedge aclk);
      aw = aw || (awvalid && awready);
      w = w || (wvalid && wready);
      @(posedge aclk);
      awvalid <= !aw;
      wvalid <= !w;
      guard(k);
    end
    aw = 0;
    while (!aw) begin
      @(negedge aclk);
      aw = bvalid && bready;
      @(posedge aclk);
      guard(k);
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [6:0] idx, input logic [31:0] e, m,
                    input logic [1:0] r);
    bit t;
    int k;
    @(posedge aclk);
    rq.push_back({e, m, r});
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    t = 0;
    k = 0;
    while (!t) begin
      @(negedge aclk);
      t = arvalid && arready;
      @(posedge aclk);
      guard(k);
    end
    arvalid <= 1'b0;
    t = 0;
    while (!t) begin
      @(negedge aclk);
      t = rvalid && rready;
      @(posedge aclk);
      guard(k);
    end
    rready <= 1'b0;
  endtask

  task automatic res();
    @(posedge aclk);
    offs <= $random(seed);
    lux <= 16'($random(seed));
    cct <= 16'($random(seed));
    upd <= 1'b1;
    @(posedge aclk);
    upd <= 1'b0;
  endtask

  // results are compared where settled, oldest note first
  always @(negedge aclk) begin
    if (rvalid && rready) begin
      x = rq.pop_front();
      cmp_data("rdata", x.e & x.m, rdata & x.m);
      cmp_resp("rresp", x.r, rresp);
    end
    if (bvalid && bready) begin
      cmp_resp("bresp", bq.pop_front(), bresp);
    end
    if (fvalid && fready) begin
      cmp_data("flash", fq.pop_front(), {faddr, fdata});
    end
  end

  initial begin
    seed = 32'hA92D3F39;
    failures = 0;
    n_tests = 0;
    {awvalid, wvalid, bready, arvalid, rready, upd, stall} = 7'h00;
    lane0 = 1'b1;
    {awaddr, araddr, wdata, wstrb, lat} = '0;
    {offs, lux, cct} = '0;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_CTRL, 32'h04, 32'hFE, RESP_OKAY);
    rd(IDX_CNT_HI, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
    rd(IDX_PAYLOAD, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
    rd(7'h39, 32'h0, 32'hFFFFFFFF, RESP_DECERR);
    wr(7'h39, 8'h12, RESP_DECERR);
    res();
    rd(IDX_LUX_HI, {24'h0, lux[15:8]}, 32'hFFFFFFFF, RESP_OKAY);
    old = lux;
    res();
    rd(IDX_LUX_LO, {24'h0, old[7:0]}, 32'hFFFFFFFF, RESP_OKAY);
    rd(IDX_CCT_HI, {24'h0, cct[15:8]}, 32'hFFFFFFFF, RESP_OKAY);
    rd(IDX_CCT_LO, {24'h0, cct[7:0]}, 32'hFFFFFFFF, RESP_OKAY);
    rd(IDX_OFFSET, offs, 32'hFFFFFFFF, RESP_OKAY);
    wr(IDX_LUX_HI, 8'hFF, RESP_OKAY);
    wr(IDX_PAYLOAD, 8'h55, RESP_OKAY);
    rd(IDX_CTRL, 32'h06, 32'hFE, RESP_OKAY);
    wr(IDX_CTRL, 8'h80, RESP_OKAY);
    rd(IDX_CTRL, 32'h84, 32'hE6, RESP_OKAY);
    // a zero-sum image so the checksum flag must come up
    sum = 8'h00;
    for (int i = 0; i < int'(SIZE); i++) begin
      b = (i == int'(SIZE) - 1) ? 8'h00 - sum : 8'($random(seed));
      sum = sum + b;
      lat <= {1'b0, b[0]};
      fq.push_back({IMG2_BASE + 24'(i), b});
      wr(IDX_PAYLOAD, b, RESP_OKAY);
      rd(IDX_CNT_LO, 32'(i + 1), 32'hFF, RESP_OKAY);
    end
    rd(IDX_CTRL, 32'hA5, 32'hFF, RESP_OKAY);
    wr(IDX_PAYLOAD, 8'h99, RESP_OKAY);
    rd(IDX_CNT_LO, {16'h0, SIZE}, 32'hFF, RESP_OKAY);
    rd(IDX_CNT_HI, {24'h0, SIZE[15:8]}, 32'hFF, RESP_OKAY);
    wr(IDX_CTRL, 8'h40, RESP_OKAY);
    rd(IDX_CTRL, 32'h04, 32'hE6, RESP_OKAY);
    rd(IDX_CNT_LO, 32'h0, 32'hFF, RESP_OKAY);
    wr(IDX_CTRL, 8'h18, RESP_OKAY);
    rd(IDX_CTRL, 32'h10, 32'hFE, RESP_OKAY);
    cmp_data("boot_lock", 32'h1, {31'h0, lock});
    cmp_data("first_image", 32'h0, {31'h0, first});
    wr(IDX_CTRL, 8'h80, RESP_OKAY);
    // lane zero off: byte ignored, nothing counted, pushed or stored
    lane0 = 1'b0;
    wr(IDX_PAYLOAD, 8'hAB, RESP_OKAY);
    lane0 = 1'b1;
    rd(IDX_PAYLOAD, 32'h99, 32'hFFFFFFFF, RESP_OKAY);
    rd(IDX_CNT_LO, 32'h0, 32'hFF, RESP_OKAY);
    // flash held off: the second byte must be refused and flagged
    stall <= 1'b1;
    fq.push_back({IMG1_BASE, 8'h3C});
    wr(IDX_PAYLOAD, 8'h3C, RESP_OKAY);
    wr(IDX_PAYLOAD, 8'h77, RESP_OKAY);
    rd(IDX_CTRL, 32'h82, 32'hE6, RESP_OKAY);
    rd(IDX_CNT_LO, 32'h1, 32'hFF, RESP_OKAY);
    stall <= 1'b0;
    n = 0;
    while (fq.size() > 0 && n < 50) begin
      @(posedge aclk);
      n++;
    end
    cmp_data("flash_left", 32'h0, 32'(fq.size()));
    summarize();
  end
endmodule // rfu_regs_tb
`default_nettype wire
